// file: security_erase_and_freeze_handler.sv
// Security erase and freeze command handler inside the drive
`timescale 1ns/1ps
`include "sec_cmd_consts.svh"
// Overview of operation
// - Opcode F4h written to the command register starts security erase.
// - Successful erase writes blocks 0 to highest native, then drops lock.
// - Erase range ignores reduced host maximum; hidden areas are erased.
// - Erase requests exactly one parameter sector before proceeding.
// - Lock disabled and user identifier selected: abort the erase.
// - Lock enabled and password mismatch: abort with aborted error.
// - Word 0 bit 0 picks user (0) or master (1) password.
// - Word 0 bit 1 picks enhanced mode; only normal erase is done.
// - Erase writes zeros and never reads them back.
// - Defect list and reassignment map stay unchanged by the erase.
// - Erase not directly after a completed prepare is aborted.
// - Master password kept after erase; new user password relocks.
// - Lock disabled and not aborted: skip comparison, just erase.
// - Erase duration reported in identify word 89.
// - Opcode F5h freezes immediately with no data transfer.
// - Frozen: reject set password, unlock, disable password, erase.
// - Frozen persists over commands and resets until power removal.
// - Prepare completes without requesting any data.
module security_erase_and_freeze_handler #(
	parameter int ADDR_W = 48,
	parameter logic [15:0] ERASE_TIME = `ERASE_TIME_MIN
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic power_on_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_in,
	input wire logic data_write_in,
	input wire logic [15:0] data_in,
	input wire logic [ADDR_W-1:0] highest_native_block_in,
	input wire logic lock_enabled_in,
	input wire logic [255:0] user_password_in,
	input wire logic [255:0] master_password_in,
	input wire logic media_ack_in,
	output logic [7:0] command_error_report_out,
	output logic [7:0] command_status_report_out,
	output logic media_write_out,
	output logic [ADDR_W-1:0] media_block_out,
	output logic lock_disable_out,
	output logic frozen_out,
	output logic [15:0] identify_word89_out
);
	initial begin
		if (ADDR_W < 8 || ADDR_W > 64)
			$error("ADDR_W must lie between 8 and 64");
		if (`PW_LAST_WORD - `PW_FIRST_WORD + 1 != 16)
			$error("password must span sixteen parameter words");
		if (`SECTOR_WORDS > 512 || `SECTOR_WORDS <= `PW_LAST_WORD)
			$error("parameter sector length out of counter range");
	end

	typedef struct packed {
		sec_cmd_pkg::ctl_state_t state;
		logic [7:0] err;
		logic [7:0] status;
		logic [8:0] word_cnt;
		logic ident_master;
		logic prepared;
		logic frozen;
		logic lock_disable;
		logic [15:0] word89;
	} ctl_t;
	ctl_t s_r, s_nxt;

	logic cmp_start;
	logic cmp_valid;
	logic user_match;
	logic master_match;
	logic sweep_start;
	logic sweep_req;
	logic [ADDR_W-1:0] sweep_addr;
	logic sweep_done;
	logic is_pw_word;
	logic [3:0] pw_idx;
	logic [8:0] pw_off;

	// Password words are parameter words 1 to 16
	always_comb begin
		is_pw_word = (s_r.word_cnt >= 9'(`PW_FIRST_WORD)) &&
			(s_r.word_cnt <= 9'(`PW_LAST_WORD));
		pw_off = s_r.word_cnt - 9'(`PW_FIRST_WORD);
		pw_idx = pw_off[3:0];
	end
	assign cmp_start = cmd_write_in && (s_r.state == sec_cmd_pkg::ST_IDLE);
	assign cmp_valid = (s_r.state == sec_cmd_pkg::ST_RECV) &&
		data_write_in && is_pw_word;

	// Two comparators, one per stored password
	pw_compare #(.WORDS(16)) u_cmp_user (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.start_in(cmp_start),
		.word_valid_in(cmp_valid),
		.word_idx_in(pw_idx),
		.word_in(data_in),
		.stored_in(user_password_in),
		.match_out(user_match)
	);
	pw_compare #(.WORDS(16)) u_cmp_master (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.start_in(cmp_start),
		.word_valid_in(cmp_valid),
		.word_idx_in(pw_idx),
		.word_in(data_in),
		.stored_in(master_password_in),
		.match_out(master_match)
	);

	// Zero-write sweep over the native range; host limits never reach it
	block_sweeper #(.ADDR_W(ADDR_W)) u_sweep (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.start_in(sweep_start),
		.last_in(highest_native_block_in),
		.ack_in(media_ack_in),
		.req_out(sweep_req),
		.addr_out(sweep_addr),
		.done_out(sweep_done)
	);

	// Command sequencing, checks and status reporting
	always_comb begin
		s_nxt = s_r;
		sweep_start = 1'b0;
		s_nxt.lock_disable = 1'b0;
		s_nxt.word89 = ERASE_TIME;
		if (!power_on_in)
			s_nxt.frozen = 1'b0;
		case (s_r.state)
			sec_cmd_pkg::ST_IDLE: begin
				if (cmd_write_in) begin
					s_nxt.err = `ERROR_RESET;
					s_nxt.status = `STATUS_RESET;
					s_nxt.status[`ST_BUSY_BIT] = 1'b1;
					s_nxt.prepared = 1'b0;
					s_nxt.state = sec_cmd_pkg::ST_DONE;
					case (cmd_in)
						`OPC_ERASE_PREPARE: begin
							s_nxt.prepared = !s_r.frozen;
							if (s_r.frozen)
								s_nxt.err[`ERR_ABORT_BIT] = 1'b1;
						end
						`OPC_ERASE_UNIT: begin
							if (s_r.frozen || !s_r.prepared) begin
								s_nxt.err[`ERR_ABORT_BIT] = 1'b1;
							end else begin
								s_nxt.word_cnt = '0;
								s_nxt.status[`ST_BUSY_BIT] = 1'b0;
								s_nxt.status[`ST_DRQ_BIT] = 1'b1;
								s_nxt.state = sec_cmd_pkg::ST_RECV;
							end
						end
						`OPC_FREEZE_LOCK:
							s_nxt.frozen = 1'b1;
						`OPC_SET_PASSWORD, `OPC_UNLOCK,
						`OPC_DISABLE_PASSWORD: begin
							if (s_r.frozen)
								s_nxt.err[`ERR_ABORT_BIT] = 1'b1;
						end
						default: begin
							s_nxt.status[`ST_BUSY_BIT] = 1'b1;
						end
					endcase
				end
			end
			sec_cmd_pkg::ST_RECV: begin
				if (data_write_in) begin
					if (s_r.word_cnt == 9'd0) begin
						s_nxt.ident_master = data_in[`CTL_IDENT_BIT];
						// Mode bit ignored: normal erase only
					end
					s_nxt.word_cnt = s_r.word_cnt + 9'd1;
					if (s_r.word_cnt == 9'(`SECTOR_WORDS - 1)) begin
						s_nxt.status[`ST_DRQ_BIT] = 1'b0;
						s_nxt.status[`ST_BUSY_BIT] = 1'b1;
						s_nxt.state = sec_cmd_pkg::ST_CHECK;
					end
				end
			end
			sec_cmd_pkg::ST_CHECK: begin
				if (!lock_enabled_in && !s_r.ident_master) begin
					s_nxt.err[`ERR_ABORT_BIT] = 1'b1;
					s_nxt.state = sec_cmd_pkg::ST_DONE;
				end else if (lock_enabled_in && (s_r.ident_master ?
					!master_match : !user_match)) begin
					s_nxt.err[`ERR_ABORT_BIT] = 1'b1;
					s_nxt.state = sec_cmd_pkg::ST_DONE;
				end else begin
					sweep_start = 1'b1;
					s_nxt.state = sec_cmd_pkg::ST_ERASE;
				end
			end
			sec_cmd_pkg::ST_ERASE: begin
				// Write-only sweep, no verify, no defect map touch
				if (sweep_done) begin
					s_nxt.lock_disable = 1'b1;
					s_nxt.state = sec_cmd_pkg::ST_DONE;
				end
			end
			sec_cmd_pkg::ST_DONE: begin
				s_nxt.status = `STATUS_RESET;
				s_nxt.status[`ST_ERR_BIT] = s_r.err[`ERR_ABORT_BIT];
				s_nxt.state = sec_cmd_pkg::ST_IDLE;
			end
			default: s_nxt.state = sec_cmd_pkg::ST_IDLE;
		endcase
	end

	// State register; frozen survives reset, lost only with power
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			s_r.state <= sec_cmd_pkg::ST_IDLE;
			s_r.err <= `ERROR_RESET;
			s_r.status <= `STATUS_RESET;
			s_r.word_cnt <= '0;
			s_r.ident_master <= 1'b0;
			s_r.prepared <= 1'b0;
			// A command seen during reset must not freeze the drive
			s_r.frozen <= s_r.frozen && power_on_in;
			s_r.lock_disable <= 1'b0;
			s_r.word89 <= ERASE_TIME;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign command_error_report_out = s_r.err;
	assign command_status_report_out = s_r.status;
	assign media_write_out = sweep_req;
	assign media_block_out = sweep_addr;
	assign lock_disable_out = s_r.lock_disable;
	assign frozen_out = s_r.frozen;
	assign identify_word89_out = s_r.word89;
endmodule

// file: sec_cmd_consts.svh
// Constants for the security erase and freeze command handler
`ifndef SEC_CMD_CONSTS_SVH
`define SEC_CMD_CONSTS_SVH
`define OPC_SET_PASSWORD 8'hF1
`define OPC_UNLOCK 8'hF2
`define OPC_ERASE_PREPARE 8'hF3
`define OPC_ERASE_UNIT 8'hF4
`define OPC_FREEZE_LOCK 8'hF5
`define OPC_DISABLE_PASSWORD 8'hF6
`define CTL_IDENT_BIT 0
`define CTL_MODE_BIT 1
`define PW_FIRST_WORD 1
`define PW_LAST_WORD 16
`define SECTOR_WORDS 256
`define ERR_ABORT_BIT 2
`define ST_BUSY_BIT 7
`define ST_READY_BIT 6
`define ST_SEEK_BIT 4
`define ST_DRQ_BIT 3
`define ST_ERR_BIT 0
`define STATUS_RESET 8'h50
`define ERROR_RESET 8'h00
`define ERASE_TIME_MIN 16'h0001
`endif

// file: sec_cmd_pkg.sv
// Types for the security erase and freeze command handler
package sec_cmd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RECV = 3'b001,
		ST_CHECK = 3'b010,
		ST_ERASE = 3'b011,
		ST_DONE = 3'b100
	} ctl_state_t;
endpackage

// file: pw_compare.sv
// Word-serial comparator of a received password against a stored one
`timescale 1ns/1ps
module pw_compare #(
	parameter int WORDS = 16
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic start_in,
	input wire logic word_valid_in,
	input wire logic [3:0] word_idx_in,
	input wire logic [15:0] word_in,
	input wire logic [16*WORDS-1:0] stored_in,
	output logic match_out
);
	initial begin
		if (WORDS != 16)
			$error("pw_compare serves a 16-word password only");
	end
	typedef struct packed {
		logic match;
	} cmp_t;
	cmp_t s_r, s_nxt;
	// Set match on start, drop match on any differing word
	always_comb begin
		s_nxt = s_r;
		if (start_in) begin
			s_nxt.match = 1'b1;
		end else if (word_valid_in) begin
			if (word_in != stored_in[word_idx_in*16 +: 16])
				s_nxt.match = 1'b0;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (reset_in)
			s_r <= '{match: 1'b0};
		else
			s_r <= s_nxt;
	end
	assign match_out = s_r.match;
endmodule

// file: block_sweeper.sv
// Walks block addresses from zero to the highest native block
`timescale 1ns/1ps
module block_sweeper #(
	parameter int ADDR_W = 48
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic start_in,
	input wire logic [ADDR_W-1:0] last_in,
	input wire logic ack_in,
	output logic req_out,
	output logic [ADDR_W-1:0] addr_out,
	output logic done_out
);
	initial begin
		if (ADDR_W < 1)
			$error("block_sweeper needs an address");
	end
	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
		logic done;
	} sw_t;
	sw_t s_r, s_nxt;
	// Issue one zero-write per block, advance on acknowledge
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (start_in) begin
			s_nxt.req = 1'b1;
			s_nxt.addr = '0;
		end else if (s_r.req && ack_in) begin
			if (s_r.addr == last_in) begin
				s_nxt.req = 1'b0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.addr = s_r.addr + 1'b1;
			end
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (reset_in)
			s_r <= '{req: 1'b0, addr: '0, done: 1'b0};
		else
			s_r <= s_nxt;
	end
	assign req_out = s_r.req;
	assign addr_out = s_r.addr;
	assign done_out = s_r.done;
endmodule

// file: sec_erase_asserts.sv
// Concurrent checks on the ports of the security command handler
`timescale 1ns/1ps
module sec_erase_asserts #(
	parameter int ADDR_W = 48,
	parameter logic [15:0] ERASE_TIME = 16'h0001
) (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic power_on_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_in,
	input wire logic media_ack_in,
	input wire logic [7:0] command_error_report_out,
	input wire logic [7:0] command_status_report_out,
	input wire logic media_write_out,
	input wire logic [ADDR_W-1:0] media_block_out,
	input wire logic lock_disable_out,
	input wire logic frozen_out,
	input wire logic [15:0] identify_word89_out
);
	logic [7:0] st;
	logic idle;
	logic take;
	logic prep_r;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	// A command is taken only while neither busy nor requesting data
	assign st = command_status_report_out;
	assign idle = !st[7] && !st[3];
	assign take = cmd_write_in && idle;
	// Remembers whether the last taken command was an accepted prepare
	always_ff @(posedge sys_clk_in) begin
		if (reset_in)
			prep_r <= 1'b0;
		else if (take)
			prep_r <= cmd_in == 8'hF3 && !frozen_out;
	end
	erase_drq_a: assert property (
		take && cmd_in == 8'hF4 && !frozen_out && prep_r |=> st[3])
		else $error("erase gave no data request");
	erase_abort_a: assert property (
		take && cmd_in == 8'hF4 && (frozen_out || !prep_r) |=>
		st == 8'hD0 ##1 st == 8'h51 && command_error_report_out == 8'h04)
		else $error("unprepared or frozen erase not aborted");
	short_busy_a: assert property (
		take && cmd_in != 8'hF4 |=> st[7] && !st[3] ##1 !st[7])
		else $error("short command busy timing wrong");
	freeze_now_a: assert property (
		take && cmd_in == 8'hF5 |-> ##[1:2] frozen_out)
		else $error("freeze not entered");
	frozen_keep_a: assert property (
		frozen_out && power_on_in |=> frozen_out)
		else $error("frozen state lost while powered");
	frozen_quiet_a: assert property (
		frozen_out |-> !media_write_out && !lock_disable_out)
		else $error("erase activity while frozen");
	abort_flag_a: assert property (
		idle && st[0] |-> command_error_report_out[2])
		else $error("error bit without abort flag");
	media_hold_a: assert property (
		media_write_out && !media_ack_in |=>
		media_write_out && $stable(media_block_out))
		else $error("write request dropped before ack");
	lock_end_a: assert property (
		lock_disable_out |=> !lock_disable_out && st == 8'h50)
		else $error("lock release pulse or end status wrong");
	erase_time_a: assert property (
		identify_word89_out == ERASE_TIME)
		else $error("identify word 89 wrong");
endmodule
bind security_erase_and_freeze_handler sec_erase_asserts #(
	.ADDR_W(ADDR_W), .ERASE_TIME(ERASE_TIME)) sec_erase_asserts_i (
	.sys_clk_in(sys_clk_in), .reset_in(reset_in),
	.power_on_in(power_on_in), .cmd_write_in(cmd_write_in),
	.cmd_in(cmd_in), .media_ack_in(media_ack_in),
	.command_error_report_out(command_error_report_out),
	.command_status_report_out(command_status_report_out),
	.media_write_out(media_write_out), .media_block_out(media_block_out),
	.lock_disable_out(lock_disable_out), .frozen_out(frozen_out),
	.identify_word89_out(identify_word89_out));

// file: media_model.sv
// Medium model that acknowledges zero-writes after a random delay
`timescale 1ns/1ps
module media_model (
	input wire logic clk_in,
	input wire logic req_in,
	output logic ack_out
);
	logic [1:0] wait_r = 2'b00;
	initial ack_out = 1'b0;
	// Write path only; nothing is ever read back
	always @(posedge clk_in) begin
		if (ack_out || !req_in) begin
			ack_out <= 1'b0;
			wait_r <= 2'($urandom);
		end else if (wait_r == 2'b00) begin
			ack_out <= 1'b1;
		end else begin
			wait_r <= wait_r - 2'b01;
		end
	end
endmodule

// file: tb.sv
// Self-checking bench for the security erase and freeze handler
`timescale 1ns/1ps
module tb;
	localparam logic [15:0] ET = 16'h00A5;
	logic clk = 0, rst = 1, pwr = 0, cw = 0, dw = 0, lock = 1, prev = 0;
	logic [7:0] op = 8'h00, hi = 8'h00, err, st, blk;
	logic [15:0] din = 16'h0000, w89;
	logic [255:0] upw = 0, mpw = 0;
	logic mw, ack, ld, frz;
	int n_fail = 0, cmp_count = 0, nblk = 0, nld = 0;
	logic [15:0] exp_q[$];
	logic [7:0] ops[5] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6};
	always #10 clk = ~clk;
	security_erase_and_freeze_handler #(.ADDR_W(8), .ERASE_TIME(ET))
		security_erase_and_freeze_handler_i (.sys_clk_in(clk),
		.reset_in(rst), .power_on_in(pwr), .cmd_write_in(cw), .cmd_in(op),
		.data_write_in(dw), .data_in(din), .highest_native_block_in(hi),
		.lock_enabled_in(lock), .user_password_in(upw),
		.master_password_in(mpw), .media_ack_in(ack),
		.command_error_report_out(err), .command_status_report_out(st),
		.media_write_out(mw), .media_block_out(blk),
		.lock_disable_out(ld), .frozen_out(frz), .identify_word89_out(w89));
	media_model media_model_i (.clk_in(clk), .req_in(mw), .ack_out(ack));
	task automatic end_sim();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(string name, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", name, e, g);
		end
	endtask
	// Issue a command, feed one sector if asked, wait until it ends
	task automatic run(logic [7:0] c, logic [15:0] ctl, logic [255:0] pw,
		logic [15:0] e);
		int i;
		exp_q.push_back(e);
		@(negedge clk);
		cw = 1;
		op = c;
		@(negedge clk);
		cw = 0;
		if (c == 8'hF3 || c == 8'hF5) chk("drq", 0, 16'(st[3]));
		if (st[3] === 1'b1) begin
			for (i = 0; i < 256; i++) begin
				dw = 1;
				din = i == 0 ? ctl : i < 17 ? pw[i*16-16+:16] : 16'($urandom);
				@(negedge clk);
			end
			dw = 0;
		end
		for (i = 0; i < 1000 && (st[7] | st[3]) !== 1'b0; i++) @(negedge clk);
		if (i == 1000) begin
			n_fail++;
			end_sim();
		end
		repeat (3) @(negedge clk);
	endtask
	// Each finished command is compared with the oldest note
	always @(posedge clk) begin
		prev <= st[7] | st[3];
		if (prev === 1'b1 && (st[7] | st[3]) === 1'b0)
			chk("result", exp_q.size() ? exp_q.pop_front() : 16'hFFFF,
				{st, err});
		if (mw === 1'b1 && ack === 1'b1) begin
			chk("block", 16'(nblk), 16'(blk));
			nblk++;
		end
		if (ld === 1'b1) nld++;
	end
	// Main sequence
	initial begin
		void'($urandom(70834));
		for (int k = 0; k < 8; k++) begin
			upw[k*32+:32] = $urandom;
			mpw[k*32+:32] = $urandom;
		end
		hi = 8'(3 + $urandom % 4);
		repeat (2) @(negedge clk);
		rst = 0;
		pwr = 1;
		chk("idle", 16'h5000, {st, err});
		chk("word89", ET, w89);
		run(8'hF4, 0, mpw, 16'h5104);
		run(8'hF3, 0, 0, 16'h5000);
		run(8'hF4, 0, mpw, 16'h5104);
		run(8'hF3, 0, 0, 16'h5000);
		nblk = 0;
		run(8'hF4, 16'h0003, mpw, 16'h5000);
		chk("blocks", 16'(hi) + 16'h0001, 16'(nblk));
		chk("lock_off", 1, 16'(nld));
		lock = 0;
		run(8'hF3, 0, 0, 16'h5000);
		run(8'hF4, 0, upw, 16'h5104);
		run(8'hF3, 0, 0, 16'h5000);
		nblk = 0;
		run(8'hF4, 16'h0001, upw, 16'h5000);
		chk("blocks", 16'(hi) + 16'h0001, 16'(nblk));
		run(8'hF5, 0, 0, 16'h5000);
		chk("frozen", 1, 16'(frz));
		foreach (ops[k]) run(ops[k], 0, upw, 16'h5104);
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		chk("frozen", 1, 16'(frz));
		pwr = 0;
		@(negedge clk);
		pwr = 1;
		@(negedge clk);
		chk("frozen", 0, 16'(frz));
		end_sim();
	end
endmodule
